/* File: design/vdw_regs.svh */
`ifndef VDW_REGS_SVH
`define VDW_REGS_SVH
// Register offsets on the software port
`define VDW_REG_CTRL 3'h0
`define VDW_REG_ROW 3'h1
`define VDW_REG_COL 3'h2
`define VDW_REG_DATA 3'h3
`define VDW_REG_MASK 3'h4
`define VDW_REG_STOP 3'h5
`define VDW_REG_RDATA 3'h6
// Control register fields
`define VDW_CTRL_CMD 3:0
`define VDW_CTRL_GO 4
// Status bits read back at the control offset
`define VDW_ST_BUSY 0
`define VDW_ST_OLD_MASK 1
`define VDW_ST_STOP_SET 2
`define VDW_ST_ERR 3
// Widths of the device pins
`define VDW_AW 9
`define VDW_DW 16
// Stop codes on address bits seven to four
`define VDW_STOP_1 4'hf
`define VDW_STOP_2 4'h7
`define VDW_STOP_4 4'h3
`define VDW_STOP_8 4'h1
`define VDW_STOP_16 4'h0
// Reset values
`define VDW_ADDR_RST 9'h000
`define VDW_DATA_RST 16'h0000
`endif

/* File: design/vdw_pkg.sv */
package vdw_pkg;
	// Cycle kinds that software may order
	typedef enum logic [3:0] {
		VDW_NWR, VDW_MWR, VDW_BWR, VDW_MBWR, VDW_FLASH, VDW_LDMASK, VDW_LDCOLOR,
		VDW_CBR_RESET, VDW_CBR_STOP, VDW_CBR_KEEP, VDW_ROR, VDW_HID_RESET,
		VDW_HID_KEEP, VDW_MWT
	} vdw_cmd_e;
	// Strobe sequencer states
	typedef enum logic [3:0] {
		VDW_IDLE, VDW_SETUP, VDW_RAS, VDW_COL, VDW_CAS, VDW_HUP, VDW_HDN, VDW_HOLD,
		VDW_PRE
	} vdw_state_e;
endpackage

/* File: design/vdw_host.sv */
// Strobed register access and the address map were left to the implementer.
`timescale 1ns/100ps
`include "vdw_regs.svh"
// Overview of operation
// - Masked or normal write chosen by write_mask_enable with select low at row fall.
// - Select low at row fall, high at column fall gives block write.
// - Enable low, select high at row fall gives masked flash write.
// - Both high at row fall loads mask or color by select at column.
// - Refresh with column first and select low resets all options.
// - Refresh with enable low, select high loads stop from address.
// - Refresh with enable and select high only refreshes.
// - Hidden refresh resets options on select low, keeps on high.
// - Masked write transfer takes pin mask in new-mask mode only.
module vdw_host import vdw_pkg::*; (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [2:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	output logic ras_n,
	output logic cas_n,
	output logic lower_byte_write_mask_enable,
	output logic upper_byte_write_mask_enable,
	output logic special_function_select,
	output logic transfer_output_enable,
	output logic [`VDW_AW-1:0] addr,
	input wire logic [`VDW_DW-1:0] data_mask_pins_i,
	output logic [`VDW_DW-1:0] data_mask_pins_o,
	output logic data_mask_pins_oe
);
	// ****************************************
	// Software registers
	// ****************************************
	vdw_state_e state_q;
	vdw_cmd_e cmd_q;
	logic [`VDW_AW-1:0] row_q, col_q;
	logic [`VDW_DW-1:0] data_q, mask_q, rdata_q, dq_s1_q, dq_s2_q;
	logic [3:0] stop_q;
	logic old_mask_q, stop_set_q, err_q;
	logic busy;
	logic stop_ok;
	// Per-command pin plan
	logic we_ras, dsf_ras, dsf_cas, mask_cmd, is_cbr, is_ror, is_hid, is_xfer, is_flash;

	assign busy = (state_q != VDW_IDLE);

	always_comb begin
		case (stop_q)
			`VDW_STOP_1, `VDW_STOP_2, `VDW_STOP_4, `VDW_STOP_8, `VDW_STOP_16: stop_ok = 1'b1;
			default: stop_ok = 1'b0;
		endcase
	end

	// Command and operand registers; an order while busy is dropped and flagged
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cmd_q <= VDW_NWR;
			row_q <= `VDW_ADDR_RST;
			col_q <= `VDW_ADDR_RST;
			data_q <= `VDW_DATA_RST;
			mask_q <= `VDW_DATA_RST;
			stop_q <= `VDW_STOP_1;
		end else if (reg_wr && !busy) begin
			if (reg_addr == `VDW_REG_CTRL) begin
				cmd_q <= vdw_cmd_e'(reg_wdata[`VDW_CTRL_CMD]);
			end else if (reg_addr == `VDW_REG_ROW) begin
				row_q <= reg_wdata[`VDW_AW-1:0];
			end else if (reg_addr == `VDW_REG_COL) begin
				col_q <= reg_wdata[`VDW_AW-1:0];
			end else if (reg_addr == `VDW_REG_DATA) begin
				data_q <= reg_wdata;
			end else if (reg_addr == `VDW_REG_MASK) begin
				mask_q <= reg_wdata;
			end else if (reg_addr == `VDW_REG_STOP) begin
				stop_q <= reg_wdata[3:0];
			end
		end
	end

	// Read port, data one cycle after the strobe; unmapped reads give zero
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			reg_rdata <= `VDW_DATA_RST;
		end else if (reg_rd) begin
			if (reg_addr == `VDW_REG_CTRL) begin
				reg_rdata <= {12'h000, err_q, stop_set_q, old_mask_q, busy};
			end else if (reg_addr == `VDW_REG_ROW) begin
				reg_rdata <= {7'h00, row_q};
			end else if (reg_addr == `VDW_REG_COL) begin
				reg_rdata <= {7'h00, col_q};
			end else if (reg_addr == `VDW_REG_DATA) begin
				reg_rdata <= data_q;
			end else if (reg_addr == `VDW_REG_MASK) begin
				reg_rdata <= mask_q;
			end else if (reg_addr == `VDW_REG_STOP) begin
				reg_rdata <= {12'h000, stop_q};
			end else if (reg_addr == `VDW_REG_RDATA) begin
				reg_rdata <= rdata_q;
			end else begin
				reg_rdata <= `VDW_DATA_RST;
			end
		end else begin
			reg_rdata <= `VDW_DATA_RST;
		end
	end

	// ****************************************
	// Pin plan for each cycle kind
	// ****************************************
	// enables low at row fall
	assign we_ras = !(cmd_q inside {VDW_MWR, VDW_MBWR, VDW_FLASH, VDW_CBR_STOP, VDW_MWT});
	assign dsf_ras = cmd_q inside {VDW_FLASH, VDW_LDMASK, VDW_LDCOLOR, VDW_CBR_STOP,
		VDW_CBR_KEEP, VDW_HID_KEEP};
	assign dsf_cas = cmd_q inside {VDW_BWR, VDW_MBWR, VDW_LDCOLOR};
	assign mask_cmd = cmd_q inside {VDW_MWR, VDW_MBWR, VDW_FLASH, VDW_MWT};
	assign is_cbr = cmd_q inside {VDW_CBR_RESET, VDW_CBR_STOP, VDW_CBR_KEEP};
	assign is_ror = (cmd_q == VDW_ROR);
	assign is_hid = cmd_q inside {VDW_HID_RESET, VDW_HID_KEEP};
	assign is_xfer = (cmd_q == VDW_MWT);
	assign is_flash = (cmd_q == VDW_FLASH);

	// ****************************************
	// Strobe sequencer
	// ****************************************
	// One clock per phase; at 100 ns a phase covers every strobe width of the part
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_q <= VDW_IDLE;
		end else begin
			case (state_q)
				VDW_IDLE: begin
					if (reg_wr && reg_addr == `VDW_REG_CTRL && reg_wdata[`VDW_CTRL_GO]) begin
						state_q <= VDW_SETUP;
					end
				end
				VDW_SETUP: begin
					if (cmd_q == VDW_CBR_STOP && !stop_ok) begin
						state_q <= VDW_IDLE;
					end else begin
						state_q <= VDW_RAS;
					end
				end
				VDW_RAS: state_q <= (is_cbr || is_ror) ? VDW_HOLD : VDW_COL;
				VDW_COL: state_q <= VDW_CAS;
				VDW_CAS: state_q <= is_hid ? VDW_HUP : VDW_HOLD;
				VDW_HUP: state_q <= VDW_HDN;
				VDW_HDN: state_q <= VDW_HOLD;
				VDW_HOLD: state_q <= VDW_PRE;
				default: state_q <= VDW_IDLE;
			endcase
		end
	end

	// Pin drive; every pin is a flop and holds its value until a later phase sets it again
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ras_n <= 1'b1;
			cas_n <= 1'b1;
			lower_byte_write_mask_enable <= 1'b1;
			upper_byte_write_mask_enable <= 1'b1;
			special_function_select <= 1'b0;
			transfer_output_enable <= 1'b1;
			addr <= `VDW_ADDR_RST;
			data_mask_pins_o <= `VDW_DATA_RST;
			data_mask_pins_oe <= 1'b0;
		end else begin
			case (state_q)
				VDW_SETUP: begin
					// An inhibited stop code is refused with every pin left at its last value
					if (cmd_q != VDW_CBR_STOP || stop_ok) begin
						// mode pins set up a phase ahead of the row fall
						lower_byte_write_mask_enable <= we_ras;
						upper_byte_write_mask_enable <= we_ras;
						// Hidden refresh opens as a plain read; its code waits for the refresh
						special_function_select <= dsf_ras && !is_hid;
						transfer_output_enable <= !is_xfer;
						// stop code rides address bits seven to four
						addr <= (cmd_q == VDW_CBR_STOP) ? {1'b0, stop_q, 4'h0} : row_q;
						cas_n <= !is_cbr;
						// old mask: pins left undriven since the device ignores them
						// new mask: pins carry the mask at the row fall
						data_mask_pins_o <= mask_q;
						data_mask_pins_oe <= mask_cmd && !old_mask_q;
					end
				end
				VDW_RAS: ras_n <= 1'b0;
				VDW_COL: begin
					// data word doubles as the per-column nibble mask
					addr <= col_q;
					special_function_select <= dsf_cas;
					data_mask_pins_o <= data_q;
					data_mask_pins_oe <= !is_hid && !is_xfer && !is_flash;
					lower_byte_write_mask_enable <= is_hid || is_xfer;
					upper_byte_write_mask_enable <= is_hid || is_xfer;
					transfer_output_enable <= !is_hid && !is_xfer;
				end
				VDW_CAS: cas_n <= 1'b0;
				VDW_HUP: begin
					ras_n <= 1'b1;
					// option code for the refresh row fall
					special_function_select <= dsf_ras;
				end
				VDW_HDN: ras_n <= 1'b0;
				VDW_HOLD: begin
					ras_n <= 1'b1;
					cas_n <= 1'b1;
					data_mask_pins_oe <= 1'b0;
					transfer_output_enable <= 1'b1;
					lower_byte_write_mask_enable <= 1'b1;
					upper_byte_write_mask_enable <= 1'b1;
				end
				default: begin
					ras_n <= 1'b1;
					cas_n <= 1'b1;
				end
			endcase
		end
	end

	// Read data from the pins passes two flops before use
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			dq_s1_q <= `VDW_DATA_RST;
			dq_s2_q <= `VDW_DATA_RST;
			rdata_q <= `VDW_DATA_RST;
		end else begin
			dq_s1_q <= data_mask_pins_i;
			dq_s2_q <= dq_s1_q;
			// Sampled late in the hidden refresh while output enable is still low
			if (state_q == VDW_HOLD && is_hid) begin
				rdata_q <= dq_s2_q;
			end
		end
	end

	// ****************************************
	// Shadow of the device option state
	// ****************************************
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			old_mask_q <= 1'b0;
			stop_set_q <= 1'b0;
		end else if (state_q == VDW_PRE) begin
			// only a mask load or full reset moves the mask mode
			if (cmd_q == VDW_LDMASK) begin
				old_mask_q <= 1'b1;
			end else if (cmd_q == VDW_CBR_RESET || cmd_q == VDW_HID_RESET) begin
				// full reset drops the stop point at once
				old_mask_q <= 1'b0;
				stop_set_q <= 1'b0;
			end else if (cmd_q == VDW_CBR_STOP) begin
				stop_set_q <= 1'b1;
			end
		end
	end

	// Error flag: refused order or inhibited stop code; a new start clears it
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			err_q <= 1'b0;
		end else if (reg_wr && busy) begin
			err_q <= 1'b1;
		end else if (state_q == VDW_SETUP && cmd_q == VDW_CBR_STOP && !stop_ok) begin
			err_q <= 1'b1;
		end else if (reg_wr && reg_addr == `VDW_REG_CTRL && reg_wdata[`VDW_CTRL_GO]) begin
			err_q <= 1'b0;
		end
	end
endmodule

/* File: dv/vdw_host_sva.sv */
`timescale 1ns/100ps
`include "vdw_regs.svh"
// ****
// Pin sequencing checks
// ****
module vdw_host_sva (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic lower_byte_write_mask_enable,
	input wire logic upper_byte_write_mask_enable,
	input wire logic special_function_select,
	input wire logic [`VDW_AW-1:0] addr,
	input wire logic data_mask_pins_oe
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	// Strobe events that start each phase
	sequence row_fall;
		$fell(ras_n);
	endsequence
	sequence col_fall;
		$fell(cas_n) && !ras_n;
	endsequence
	sequence refresh_fall;
		$fell(ras_n) && !cas_n;
	endsequence
	chk_lane_pair: assert property (lower_byte_write_mask_enable == upper_byte_write_mask_enable)
		else $error("lane enables differ");
	chk_mode_stable: assert property (row_fall |-> $stable(special_function_select)
		&& $stable(lower_byte_write_mask_enable)) else $error("mode pins moved at row fall");
	chk_col_stable: assert property (col_fall |-> $stable(addr) && $stable(special_function_select))
		else $error("column pins moved at column fall");
	chk_col_delay: assert property (col_fall |-> $past(ras_n, 3) && !$past(ras_n, 2))
		else $error("column fall not two cycles after row fall");
	chk_row_width: assert property (row_fall |-> ##[1:3] ras_n)
		else $error("row strobe held too long");
	chk_stop_code: assert property (refresh_fall ##0 (special_function_select
		&& !lower_byte_write_mask_enable) |-> addr[7:4] inside {4'hf, 4'h7, 4'h3, 4'h1, 4'h0})
		else $error("inhibited stop code sent");
	chk_refresh_quiet: assert property (refresh_fall |-> !data_mask_pins_oe)
		else $error("data pins driven in refresh");
	chk_hidden_again: assert property ($rose(ras_n) && !cas_n |-> ##1 $fell(ras_n))
		else $error("hidden refresh row strobe missing");
	chk_cas_paired: assert property ($fell(cas_n) |-> ##[0:1] !ras_n)
		else $error("column strobe fell with no row strobe");
endmodule

/* File: dv/vdw_vram_model.sv */
`timescale 1ns/100ps
// ****
// Random-port model of the video memory
// ****
module vdw_vram_model import vdw_pkg::*; #(
	parameter logic [15:0] RD_VAL = 16'h5a3c
) (
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_lo,
	input wire logic sel,
	input wire logic toe,
	input wire logic [8:0] addr,
	input wire logic [15:0] host_dq,
	input wire logic host_dq_en,
	output logic [15:0] dq_wire
);
	vdw_cmd_e kind = VDW_NWR;
	logic we_r, dsf_r, oe_r, col_seen, row_mask_en;
	logic cas_held = 1'b0;
	logic old_mask = 1'b0;
	logic stop_set = 1'b0;
	logic [3:0] stop_q = 4'h0;
	logic [15:0] row_mask, col_data, mask_q, color_q;
	logic [8:0] row_a, col_a;
	// Released pins show the inverse word so a stale read cannot pass
	assign dq_wire = host_dq_en ? host_dq : (!toe && !cas_n ? RD_VAL : ~RD_VAL);
	always @(negedge ras_n) begin
		col_seen = !cas_n;
		if (!cas_n) begin
			kind = cas_held ? (sel ? VDW_HID_KEEP : VDW_HID_RESET)
				: !sel ? VDW_CBR_RESET : we_lo ? VDW_CBR_KEEP : VDW_CBR_STOP;
			if (!sel) begin
				old_mask = 1'b0;
				stop_set = 1'b0;
			end
			if (sel && !we_lo && !cas_held) begin
				stop_q = addr[7:4];
				stop_set = 1'b1;
			end
		end else begin
			we_r = we_lo;
			dsf_r = sel;
			oe_r = toe;
			row_mask_en = host_dq_en;
			row_mask = dq_wire;
			row_a = addr;
		end
	end
	always @(negedge cas_n) begin
		if (!ras_n) begin
			col_seen = 1'b1;
			cas_held = 1'b1;
			col_data = dq_wire;
			col_a = addr;
			kind = !oe_r ? VDW_MWT : dsf_r ? (!we_r ? VDW_FLASH : sel ? VDW_LDCOLOR : VDW_LDMASK)
				: sel ? (we_r ? VDW_BWR : VDW_MBWR) : (we_r ? VDW_NWR : VDW_MWR);
			if (dsf_r && we_r && oe_r && sel) color_q = col_data;
			if (dsf_r && we_r && oe_r && !sel) begin
				mask_q = col_data;
				old_mask = 1'b1;
			end
		end
	end
	// Column release ends any hidden hold
	always @(posedge cas_n) cas_held = 1'b0;
	// A row with no column is a row-only refresh
	always @(posedge ras_n) begin
		if (!col_seen) kind = VDW_ROR;
	end
endmodule

/* File: dv/tb_video_dram_write_refresh_decode.sv */
`timescale 1ns/100ps
`include "vdw_regs.svh"
module tb_video_dram_write_refresh_decode import vdw_pkg::*;;
	logic clk_sys, rst, reg_wr, reg_rd, ras_n, cas_n, we_lo, we_hi, sel, toe, dq_oe;
	logic [2:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata, dq_o, dq_i, dv, mv, got, mreg;
	logic [8:0] addr;
	logic old_m, stop_s, err_e;
	vdw_cmd_e kind_e;
	int err_count = 0;
	int cmp_count = 0;
	logic [3:0] codes [5] = '{4'hf, 4'h7, 4'h3, 4'h1, 4'h0};
	vdw_cmd_e seq_q [$] = '{VDW_NWR, VDW_MWR, VDW_BWR, VDW_MBWR, VDW_FLASH, VDW_MWT, VDW_LDCOLOR,
		VDW_CBR_STOP, VDW_LDMASK, VDW_MWR, VDW_MBWR, VDW_CBR_KEEP, VDW_ROR, VDW_HID_KEEP,
		VDW_MWR, VDW_HID_RESET, VDW_MWR, VDW_CBR_STOP, VDW_LDMASK, VDW_CBR_RESET, VDW_MWT};
	vdw_host u_vdw_host (.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.ras_n, .cas_n, .lower_byte_write_mask_enable(we_lo), .upper_byte_write_mask_enable(we_hi),
		.special_function_select(sel), .transfer_output_enable(toe), .addr,
		.data_mask_pins_i(dq_i), .data_mask_pins_o(dq_o), .data_mask_pins_oe(dq_oe));
	vdw_vram_model #(.RD_VAL(16'h5a3c)) u_vdw_vram_model (.ras_n, .cas_n, .we_lo, .sel, .toe,
		.addr, .host_dq(dq_o), .host_dq_en(dq_oe), .dq_wire(dq_i));
	// ****
	// Bus tasks and comparison
	// ****
	// Strobe drops with an edge in between, so calls never collide
	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic rd(input logic [2:0] a, output logic [15:0] d);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(posedge clk_sys);
		d = reg_rdata;
	endtask
	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic stop_test();
		$display("compares %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// One ordered cycle: operands, start, poll idle, compare against the bench model
	task automatic run(input vdw_cmd_e c, input logic [3:0] code, input logic busy_hit);
		logic [15:0] st;
		logic [8:0] ra, ca;
		int n;
		logic bad;
		bad = (c == VDW_CBR_STOP) && !(code inside {4'hf, 4'h7, 4'h3, 4'h1, 4'h0});
		dv = 16'($urandom);
		mv = 16'($urandom);
		ra = 9'($urandom_range(511));
		ca = 9'($urandom_range(511));
		wr(`VDW_REG_ROW, {7'h0, ra});
		wr(`VDW_REG_COL, {7'h0, ca});
		wr(`VDW_REG_DATA, dv);
		wr(`VDW_REG_MASK, mv);
		wr(`VDW_REG_STOP, {12'h0, code});
		wr(`VDW_REG_CTRL, {11'h0, 1'b1, c});
		if (busy_hit) wr(`VDW_REG_CTRL, {11'h0, 1'b1, VDW_FLASH});
		n = 0;
		do begin
			rd(`VDW_REG_CTRL, st);
			n++;
		end while (st[`VDW_ST_BUSY] !== 1'b0 && n < 40);
		err_e = bad || busy_hit;
		if (!bad) kind_e = c;
		if (c == VDW_LDMASK) begin
			old_m = 1'b1;
			mreg = dv;
		end
		if (c == VDW_CBR_RESET || c == VDW_HID_RESET) begin
			old_m = 1'b0;
			stop_s = 1'b0;
		end
		if (c == VDW_CBR_STOP && !bad) stop_s = 1'b1;
		chk("status", st, {12'h0, err_e, stop_s, old_m, 1'b0});
		chk("kind", {12'h0, u_vdw_vram_model.kind}, {12'h0, kind_e});
		if (!(c inside {VDW_CBR_RESET, VDW_CBR_STOP, VDW_CBR_KEEP}))
			chk("row address", {7'h0, u_vdw_vram_model.row_a}, {7'h0, ra});
		if (!(c inside {VDW_CBR_RESET, VDW_CBR_STOP, VDW_CBR_KEEP, VDW_ROR}))
			chk("column address", {7'h0, u_vdw_vram_model.col_a}, {7'h0, ca});
		if (c inside {VDW_NWR, VDW_MWR, VDW_BWR, VDW_MBWR, VDW_LDCOLOR, VDW_LDMASK})
			chk("column data", u_vdw_vram_model.col_data, dv);
		if (c == VDW_LDCOLOR)
			chk("color register", u_vdw_vram_model.color_q, dv);
		if (old_m)
			chk("mask register", u_vdw_vram_model.mask_q, mreg);
		got = {14'h0, u_vdw_vram_model.old_mask, u_vdw_vram_model.stop_set};
		chk("device options", got, {14'h0, old_m, stop_s});
		got = old_m ? {15'h0, u_vdw_vram_model.row_mask_en} : u_vdw_vram_model.row_mask;
		if (c inside {VDW_MWR, VDW_MBWR, VDW_FLASH, VDW_MWT})
			chk("row mask", got, old_m ? 16'h0 : mv);
		if (c == VDW_CBR_STOP && !bad)
			chk("stop", {12'h0, u_vdw_vram_model.stop_q}, {12'h0, code});
		if (c inside {VDW_HID_RESET, VDW_HID_KEEP}) begin
			rd(`VDW_REG_RDATA, st);
			chk("hidden read", st, 16'h5a3c);
		end
	endtask
	// ****
	// Clock, watchdog and main sequence
	// ****
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	// Far above the roughly 460 cycles the sequence needs
	initial begin
		#2000000;
		err_count++;
		stop_test();
	end
	initial begin
		rst = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 3'h0;
		reg_wdata = 16'h0;
		old_m = 1'b0;
		stop_s = 1'b0;
		kind_e = VDW_NWR;
		void'($urandom(89));
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		foreach (seq_q[i]) run(seq_q[i], codes[$urandom_range(4)], 1'b0);
		run(VDW_CBR_STOP, 4'h5, 1'b0);
		run(VDW_NWR, 4'h0, 1'b1);
		rd(3'h7, got);
		chk("unmapped read", got, 16'h0);
		stop_test();
	end
endmodule
bind vdw_host vdw_host_sva u_vdw_host_sva (.clk_sys, .rst, .ras_n, .cas_n,
	.lower_byte_write_mask_enable, .upper_byte_write_mask_enable, .special_function_select,
	.addr, .data_mask_pins_oe);
